/* rtl/port_params_pkg.sv */
package port_params_pkg;

  // port count and field layout of one parameter word
  localparam int NumPortsDef = 20;
  localparam int PrmW = 12;
  localparam int PortIdxW = 5;
  localparam int PartnerLsb = 0;
  localparam int ExpoLsb = 5;
  localparam int ExpoW = 3;
  localparam int RangeLsb = 8;
  localparam int RangeW = 3;
  localparam int SampleW = 12;
  localparam int CntW = 8;
  localparam int AccW = SampleW + 7;
  localparam logic [PrmW-1:0] PrmReset = 12'h000;

  // register pointer map of the serial port
  localparam logic [7:0] PrmBase = 8'h00;
  localparam logic [7:0] ResBase = 8'h20;

  // serial framing
  localparam logic [3:0] BitsPerByte = 4'h8;
  localparam logic [6:0] DevAddrDef = 7'h38; // arbitrary value

  // raw range codes
  localparam logic [RangeW-1:0] CodeNone = 3'h0;
  localparam logic [RangeW-1:0] CodeZero10 = 3'h1;
  localparam logic [RangeW-1:0] CodePm5 = 3'h2;
  localparam logic [RangeW-1:0] CodeNeg10 = 3'h3;
  localparam logic [RangeW-1:0] CodeLow2p5 = 3'h4;

  // decoded voltage ranges
  typedef enum logic [2:0] {
    RngNone, RngZero10, RngPm5, RngNeg10, RngZero2p5
  } range_t;

  // serial slave states
  typedef enum logic [3:0] {
    StIdle, StAddr, StAckAddr, StPtr, StAckPtr,
    StWrite, StAckWrite, StRead, StReadAck
  } ser_state_t;

endpackage

/* rtl/port_function_parameter_decode.sv */
// Contract
// R1: bits 4:0 name the partner port used with modes 4, 8 and 11.
// R2: bits 7:5 give averaging count as two to that power, ADC use only.
// R3: ADC ports average the programmed sample count before writing their result.
// R4: averaging counts are one through 128, one per three-bit code.
// R5: bits 10:8 select the port's input or output voltage range.
// R6: host never programs range code 000 on ADC or DAC ports.
// R7: ADC decode: 000 none, 001 0..10, 010 +-5, 011 -10..0, 100 0..2.5.
// R8: DAC decode: 000 none, 001 0..10, 010 and 100 +-5, 011 -10..0.
// R9: all twenty parameter words read back the value last written.
module port_function_parameter_decode
  import port_params_pkg::*;
#(
  parameter int NumPorts = NumPortsDef,
  parameter logic [6:0] DevAddr = DevAddrDef
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // serial pins, open drain data
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // conversions from the adc sequencer
  input wire logic convValid,
  input wire logic [PortIdxW-1:0] convPort,
  input wire logic [SampleW-1:0] convData,
  // averaged results
  output logic resultValid,
  output logic [PortIdxW-1:0] resultPort,
  output logic [SampleW-1:0] resultData,
  // decoded per-port configuration
  output logic [NumPorts-1:0][PortIdxW-1:0] partnerPort,
  output logic [NumPorts-1:0][ExpoW-1:0] averagingExponent,
  output range_t [NumPorts-1:0] adcRange,
  output range_t [NumPorts-1:0] dacRange
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // reserved codes fall back to no range
  function automatic range_t adcDecode(input logic [RangeW-1:0] c);
    unique case (c)
      CodeNone: adcDecode = RngNone;
      CodeZero10: adcDecode = RngZero10;
      CodePm5: adcDecode = RngPm5;
      CodeNeg10: adcDecode = RngNeg10;
      CodeLow2p5: adcDecode = RngZero2p5;
      default: adcDecode = RngNone;
    endcase
  endfunction

  // the dac has no 2.5 V span, code 100 doubles as bipolar 5 V
  function automatic range_t dacDecode(input logic [RangeW-1:0] c);
    unique case (c)
      CodeNone: dacDecode = RngNone;
      CodeZero10: dacDecode = RngZero10;
      CodePm5: dacDecode = RngPm5;
      CodeNeg10: dacDecode = RngNeg10;
      CodeLow2p5: dacDecode = RngPm5;
      default: dacDecode = RngNone;
    endcase
  endfunction

  // samples needed before a result is written
  function automatic logic [CntW:0] sampleTarget(input logic [ExpoW-1:0] e);
    sampleTarget = (CntW+1)'(1) << e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [PrmW-1:0] prmQ [NumPorts];
  logic [SampleW-1:0] resQ [NumPorts];
  logic [AccW-1:0] accQ [NumPorts];
  logic [CntW:0] cntQ [NumPorts];

  // decoded outputs straight from the stored words
  always_comb begin
    for (int k = 0; k < NumPorts; k++) begin
      partnerPort[k] = prmQ[k][PartnerLsb +: PortIdxW]; // [R1]
      averagingExponent[k] = prmQ[k][ExpoLsb +: ExpoW]; // [R2]
      adcRange[k] = adcDecode(prmQ[k][RangeLsb +: RangeW]); // [R5] [R7]
      dacRange[k] = dacDecode(prmQ[k][RangeLsb +: RangeW]); // [R5] [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus conditions

  logic [2:0] sclSynQ;
  logic [2:0] sdaSynQ;

  // stage 0 feeds only stage 1; stage 2 is the edge history
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sclSynQ <= 3'h7;
      sdaSynQ <= 3'h7;
    end else begin
      sclSynQ <= {sclSynQ[1:0], sclIn};
      sdaSynQ <= {sdaSynQ[1:0], sdaIn};
    end
  end

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic sdaBit;

  assign sclRise = sclSynQ[1] & ~sclSynQ[2];
  assign sclFall = ~sclSynQ[1] & sclSynQ[2];
  assign startCond = sclSynQ[1] & sclSynQ[2] & sdaSynQ[2] & ~sdaSynQ[1];
  assign stopCond = sclSynQ[1] & sclSynQ[2] & ~sdaSynQ[2] & sdaSynQ[1];
  assign sdaBit = sdaSynQ[1];

  ////////////////////////////////////////////////////////////////////////////
  // serial slave

  ser_state_t stateQ;
  logic [3:0] bitCntQ;
  logic [7:0] rxQ;
  logic [15:0] txQ;
  logic [7:0] ptrQ;
  logic [7:0] hiQ;
  logic rwQ;
  logic lowByteQ;
  logic ackQ;
  logic wrEn;
  logic [PortIdxW-1:0] wrIdx;
  logic [PrmW-1:0] wrData;

  // unmapped pointers read as zero
  function automatic logic [15:0] readWord(input logic [7:0] a);
    readWord = 16'h0000;
    for (int k = 0; k < NumPorts; k++) begin
      if (a == PrmBase + 8'(k)) readWord = 16'(prmQ[k]);
      if (a == ResBase + 8'(k)) readWord = 16'(resQ[k]);
    end
  endfunction

  // a word write lands when its low byte is complete
  always_comb begin
    wrEn = 1'b0;
    wrIdx = PortIdxW'(ptrQ - PrmBase);
    wrData = PrmW'({hiQ, rxQ});
    if (sclFall && stateQ == StWrite && bitCntQ == BitsPerByte && lowByteQ &&
        ptrQ >= PrmBase && ptrQ < PrmBase + 8'(NumPorts)) begin
      wrEn = 1'b1;
    end
  end

  // bit and state sequencing on scl edges
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stateQ <= StIdle;
      bitCntQ <= 4'h0;
      rxQ <= 8'h00;
      txQ <= 16'h0000;
      ptrQ <= 8'h00;
      hiQ <= 8'h00;
      rwQ <= 1'b0;
      lowByteQ <= 1'b0;
      ackQ <= 1'b0;
    end else if (startCond) begin
      stateQ <= StAddr;
      bitCntQ <= 4'h0;
    end else if (stopCond) begin
      stateQ <= StIdle;
    end else if (sclRise) begin
      if (stateQ == StReadAck) ackQ <= ~sdaBit;
      if (stateQ inside {StAddr, StPtr, StWrite, StRead}) begin
        rxQ <= {rxQ[6:0], sdaBit};
        bitCntQ <= bitCntQ + 4'h1;
      end
    end else if (sclFall) begin
      unique case (stateQ)
        StIdle, StAckPtr: begin
          if (stateQ == StAckPtr) stateQ <= StWrite;
          bitCntQ <= 4'h0;
          lowByteQ <= 1'b0;
        end
        StAddr: if (bitCntQ == BitsPerByte) begin
          // foreign addresses drop back to idle until the next start
          stateQ <= (rxQ[7:1] == DevAddr) ? StAckAddr : StIdle;
          rwQ <= rxQ[0];
        end
        StAckAddr: begin
          bitCntQ <= 4'h0;
          lowByteQ <= 1'b0;
          if (rwQ) begin
            stateQ <= StRead;
            txQ <= readWord(ptrQ); // [R9]
          end else begin
            stateQ <= StPtr;
          end
        end
        StPtr: if (bitCntQ == BitsPerByte) begin
          stateQ <= StAckPtr;
          ptrQ <= rxQ;
        end
        StWrite: if (bitCntQ == BitsPerByte) begin
          stateQ <= StAckWrite;
          if (!lowByteQ) hiQ <= rxQ;
          else ptrQ <= ptrQ + 8'h01;
        end
        StAckWrite: begin
          stateQ <= StWrite;
          bitCntQ <= 4'h0;
          lowByteQ <= ~lowByteQ;
        end
        StRead: begin
          txQ <= {txQ[14:0], 1'b0};
          if (bitCntQ == BitsPerByte) stateQ <= StReadAck;
        end
        StReadAck: begin
          bitCntQ <= 4'h0;
          // a nack from the host ends the read burst
          if (!ackQ) begin
            stateQ <= StIdle;
          end else if (!lowByteQ) begin
            stateQ <= StRead;
            lowByteQ <= 1'b1;
          end else begin
            stateQ <= StRead;
            lowByteQ <= 1'b0;
            ptrQ <= ptrQ + 8'h01;
            txQ <= readWord(ptrQ + 8'h01); // [R9]
          end
        end
      endcase
    end
  end

  // open drain: only ever pull low, from registered state
  assign sdaOut = 1'b0;
  assign sdaOe = (stateQ inside {StAckAddr, StAckPtr, StAckWrite}) ||
                 (stateQ == StRead && !txQ[15]);

  ////////////////////////////////////////////////////////////////////////////
  // parameter words

  // upper nibble of the host word is dropped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < NumPorts; k++) prmQ[k] <= PrmReset;
    end else if (wrEn) begin
      prmQ[wrIdx] <= wrData; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample averaging

  logic convOk;
  logic [AccW-1:0] sumD;
  logic [CntW:0] cntD;
  logic [ExpoW-1:0] expoNow;

  assign convOk = convValid && (convPort < PortIdxW'(NumPorts));
  assign expoNow = averagingExponent[convPort];
  assign sumD = accQ[convPort] + AccW'(convData);
  assign cntD = cntQ[convPort] + (CntW+1)'(1);

  // >= keeps a port from stalling if its count shrinks mid-average
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < NumPorts; k++) begin
        accQ[k] <= '0;
        cntQ[k] <= '0;
        resQ[k] <= '0;
      end
      resultValid <= 1'b0;
      resultPort <= '0;
      resultData <= '0;
    end else begin
      resultValid <= 1'b0;
      if (convOk) begin
        if (cntD >= sampleTarget(expoNow)) begin // [R3] [R4]
          resQ[convPort] <= SampleW'(sumD >> expoNow);
          resultData <= SampleW'(sumD >> expoNow);
          resultPort <= convPort;
          resultValid <= 1'b1;
          accQ[convPort] <= '0;
          cntQ[convPort] <= '0;
        end else begin
          accQ[convPort] <= sumD;
          cntQ[convPort] <= cntD;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence wordWrite;
    wrEn;
  endsequence

  partner_follow_a: // [R1]
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      wordWrite |=> partnerPort[$past(wrIdx)] == $past(wrData[PartnerLsb +: PortIdxW]))
    else $error("partner index does not follow write");

  expo_follow_a: // [R2]
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      wordWrite |=> averagingExponent[$past(wrIdx)] == $past(wrData[ExpoLsb +: ExpoW]))
    else $error("averaging exponent does not follow write");

  range_bipolar_a: // [R5]
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      (wordWrite and (wrData[RangeLsb +: RangeW] == CodePm5))
      |=> adcRange[$past(wrIdx)] == RngPm5 && dacRange[$past(wrIdx)] == RngPm5)
    else $error("code 010 not bipolar on both");

  adc_low_a: // [R7]
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      (wordWrite and (wrData[RangeLsb +: RangeW] == CodeLow2p5))
      |=> adcRange[$past(wrIdx)] == RngZero2p5)
    else $error("adc code 100 wrong");

  dac_low_a: // [R8]
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      (wordWrite and (wrData[RangeLsb +: RangeW] == CodeLow2p5))
      |=> dacRange[$past(wrIdx)] == RngPm5)
    else $error("dac code 100 wrong");

  readback_hold_a: // [R9]
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      wordWrite ##1 !wrEn [*2] |-> prmQ[$past(wrIdx, 2)] == $past(wrData, 2))
    else $error("parameter word lost");

  result_cause_a: // [R3]
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      resultValid |-> $past(convOk) && resQ[resultPort] == resultData)
    else $error("result without conversion");

  single_sample_a: // [R4]
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      convOk && expoNow == '0 |=> resultValid && resultData == $past(convData))
    else $error("count of one not immediate");

endmodule

/* tb/serial_host.sv */
module serial_host (
  // bus clock reference and wire level
  input wire logic clk_sys,
  input wire logic sdaLine,
  // host pins, sda as a pull-down only
  output logic scl,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;

  // both lines start released
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic hp(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic startC();
    scl = 1'b1;
    sdaLow = 1'b0;
    hp(8);
    sdaLow = 1'b1;
    hp(8);
    scl = 1'b0;
  endtask

  task automatic stopC();
    hp(2);
    sdaLow = 1'b1;
    hp(8);
    scl = 1'b1;
    hp(8);
    sdaLow = 1'b0;
    hp(8);
  endtask

  // data moves only with scl low, so no false start or stop is seen
  task automatic bitX(input logic b, output logic s);
    hp(2);
    sdaLow = !b;
    hp(8);
    scl = 1'b1;
    hp(4);
    s = sdaLine;
    hp(4);
    scl = 1'b0;
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitX(d[i], s);
    bitX(1'b1, s);
    ack = !s;
  endtask

  task automatic recvByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitX(1'b1, s);
      d[i] = s;
    end
    bitX(!ack, s);
  endtask
endmodule

/* tb/testbench.sv */
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end

module testbench import port_params_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, rst_b, scl, sdaLow, sdaOe, sdaOut, sdaLine;
  logic convValid, resultValid;
  logic [4:0] convPort, resultPort;
  logic [11:0] convData, resultData;
  logic [19:0][4:0] partnerPort;
  logic [19:0][2:0] averagingExponent;
  range_t [19:0] adcRange, dacRange;
  logic [11:0] prm [20];
  logic [15:0] w;
  int failures, totalChecks, cycles, sum;

  // open drain wire with pull-up; an enabled device shows its own drive level
  assign sdaLine = !sdaLow && (!sdaOe || sdaOut);

  port_function_parameter_decode port_function_parameter_decode_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclIn(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .convValid(convValid), .convPort(convPort),
    .convData(convData), .resultValid(resultValid), .resultPort(resultPort),
    .resultData(resultData), .partnerPort(partnerPort),
    .averagingExponent(averagingExponent), .adcRange(adcRange), .dacRange(dacRange));

  serial_host serial_host_inst (
    .clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));

  always #2 clk_sys = !clk_sys;

  function automatic range_t adcExp(input logic [2:0] c);
    case (c)
      3'h1: return RngZero10;
      3'h2: return RngPm5;
      3'h3: return RngNeg10;
      3'h4: return RngZero2p5;
      default: return RngNone;
    endcase
  endfunction

  function automatic range_t dacExp(input logic [2:0] c);
    case (c)
      3'h1: return RngZero10;
      3'h2, 3'h4: return RngPm5;
      3'h3: return RngNeg10;
      default: return RngNone;
    endcase
  endfunction

  task automatic finish_test();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wrWord(input logic [7:0] p, input logic [15:0] d);
    logic a0, a1, a2, a3;
    serial_host_inst.startC();
    serial_host_inst.sendByte({DevAddrDef, 1'b0}, a0);
    serial_host_inst.sendByte(p, a1);
    serial_host_inst.sendByte(d[15:8], a2);
    serial_host_inst.sendByte(d[7:0], a3);
    serial_host_inst.stopC();
    `CHK("write acks", 4'hf, {a0, a1, a2, a3})
  endtask

  task automatic rdWord(input logic [7:0] p, output logic [15:0] d);
    logic a;
    serial_host_inst.startC();
    serial_host_inst.sendByte({DevAddrDef, 1'b0}, a);
    serial_host_inst.sendByte(p, a);
    serial_host_inst.stopC();
    serial_host_inst.startC();
    serial_host_inst.sendByte({DevAddrDef, 1'b1}, a);
    serial_host_inst.recvByte(1'b1, d[15:8]);
    serial_host_inst.recvByte(1'b0, d[7:0]);
    serial_host_inst.stopC();
  endtask

  // a hung bus would stall forever, so cycles are capped
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    convValid = 1'b0;
    convPort = 5'h00;
    convData = 12'h000;
    void'($urandom(96));
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    // reset state of every port
    for (int i = 0; i < 20; i++) begin
      `CHK("partner rst", 5'h00, partnerPort[i])
      `CHK("adc rst", RngNone, adcRange[i])
      `CHK("dac rst", RngNone, dacRange[i])
      `CHK("exponent rst", 3'h0, averagingExponent[i])
    end
    `CHK("sda released", 1'b0, sdaOe)
    `CHK("sda level", 1'b0, sdaOut)
    $display("test reset done");
    // random words; range code i mod 8 so every code is decoded
    for (int i = 0; i < 20; i++) begin
      w = 16'($urandom);
      w[10:8] = 3'(i);
      prm[i] = w[11:0];
      wrWord(8'(i), w);
    end
    for (int i = 0; i < 20; i++) begin
      `CHK("partner", prm[i][4:0], partnerPort[i])
      `CHK("exponent", prm[i][7:5], averagingExponent[i])
      `CHK("adc range", adcExp(prm[i][10:8]), adcRange[i])
      `CHK("dac range", dacExp(prm[i][10:8]), dacRange[i])
      rdWord(8'(i), w);
      `CHK("readback", {4'h0, prm[i]}, w)
    end
    // pointers past the last port are acked, dropped and read as zero
    wrWord(8'h14, 16'h0fff);
    rdWord(8'h14, w);
    `CHK("unmapped read", 16'h0000, w)
    $display("test decode done");
    // every averaging count, a fresh port each, range never 000 on an adc port
    for (int e = 0; e < 8; e++) begin
      wrWord(8'(e + 4), {5'h00, 3'h1, 3'(e), 5'h00});
      sum = 0;
      for (int k = 0; k < (1 << e); k++) begin
        convValid = 1'b1;
        convPort = 5'(e + 4);
        convData = 12'($urandom);
        sum += convData;
        @(negedge clk_sys);
        if (k < (1 << e) - 1) `CHK("early result", 1'b0, resultValid)
      end
      convValid = 1'b0;
      `CHK("result valid", 1'b1, resultValid)
      `CHK("result port", 5'(e + 4), resultPort)
      `CHK("result data", 12'(sum >> e), resultData)
      rdWord(ResBase + 8'(e + 4), w);
      `CHK("result readback", {4'h0, 12'(sum >> e)}, w)
    end
    $display("test averaging done");
    finish_test();
  end
endmodule
